// file: sensor_resp_pkg.sv
package sensor_resp_pkg;

	// Clock and link timing
	localparam int CLK_HZ           = 50_000_000;
	localparam int BAUD             = 1200;
	localparam int BIT_CYCLES       = CLK_HZ / BAUD;
	localparam int FRAME_BITS       = 10;
	localparam int RAISE_MS         = 50;
	localparam int RAISE_MAX_MS     = 100;
	localparam int RAISE_CYCLES     = RAISE_MS * (CLK_HZ / 1000);
	localparam int RAISE_MAX_CYCLES = RAISE_MAX_MS * (CLK_HZ / 1000);
	localparam int CNT_W            = 23;
	localparam int BIT_CNT_W        = 16;
	localparam int CMD_MAX          = 3;

	// Characters
	localparam logic [7:0] CH_TAB   = 8'h09;
	localparam logic [7:0] CH_LF    = 8'h0A;
	localparam logic [7:0] CH_CR    = 8'h0D;
	localparam logic [7:0] CH_SP    = 8'h20;
	localparam logic [7:0] CH_BANG  = 8'h21;
	localparam logic [7:0] CH_PLUS  = 8'h2B;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_DOT   = 8'h2E;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_NINE  = 8'h39;
	localparam logic [7:0] CH_WILD  = 8'h3F;
	localparam logic [7:0] CH_A     = 8'h41;
	localparam logic [7:0] CH_D     = 8'h44;
	localparam logic [7:0] CH_UP_Z  = 8'h5A;
	localparam logic [7:0] CH_LO_A  = 8'h61;
	localparam logic [7:0] CH_LO_Z  = 8'h7A;

	// Values after reset and checksum offset
	localparam logic [7:0] ADDR_RESET  = 8'h30;
	localparam logic [7:0] CSUM_OFFSET = 8'h20;

	// Response steps
	localparam logic [4:0] STEP_PREFIX    = 5'h00;
	localparam logic [4:0] STEP_CSIGN     = 5'h01;
	localparam logic [4:0] STEP_CDIG0     = 5'h02;
	localparam logic [4:0] STEP_CDIG_LAST = 5'h07;
	localparam logic [4:0] STEP_SEP       = 5'h08;
	localparam logic [4:0] STEP_TSIGN     = 5'h09;
	localparam logic [4:0] STEP_TTENS     = 5'h0A;
	localparam logic [4:0] STEP_TUNITS    = 5'h0B;
	localparam logic [4:0] STEP_DOT       = 5'h0C;
	localparam logic [4:0] STEP_TFRAC     = 5'h0D;
	localparam logic [4:0] STEP_MCR       = 5'h0E;
	localparam logic [4:0] STEP_TYPE      = 5'h0F;
	localparam logic [4:0] STEP_CSUM      = 5'h10;
	localparam logic [4:0] STEP_CR        = 5'h11;
	localparam logic [4:0] STEP_LF        = 5'h12;

	function automatic logic is_alnum(input logic [7:0] c);
		return (c >= CH_ZERO && c <= CH_NINE) || (c >= CH_A && c <= CH_UP_Z) || (c >= CH_LO_A && c <= CH_LO_Z);
	endfunction

endpackage

// file: serial_char_tx.sv
`timescale 1ns/1ps
module serial_char_tx #(
	parameter int BIT_CYCLES = sensor_resp_pkg::BIT_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       start_i,
	input  wire logic [7:0] data_i,
	input  wire logic       sdi_mode_i,
	output logic            line_o,
	output logic            done_o
);
	localparam int W = sensor_resp_pkg::BIT_CNT_W;

	logic         busy_reg,  busy_next;
	logic         mode_reg,  mode_next;
	logic [W-1:0] cnt_reg,   cnt_next;
	logic [3:0]   bit_reg,   bit_next;
	logic [9:0]   shift_reg, shift_next;
	logic         line_reg,  line_next;
	logic         done_reg,  done_next;

	always_comb begin
		busy_next  = busy_reg;
		mode_next  = mode_reg;
		cnt_next   = cnt_reg;
		bit_next   = bit_reg;
		shift_next = shift_reg;
		line_next  = busy_reg ? line_reg : !sdi_mode_i;
		done_next  = 1'b0;
		if (!busy_reg) begin
			if (start_i) begin
				// Inverted 7E1 for the bus, plain 8N1 for the broadcast
				shift_next = sdi_mode_i ? {1'b1, ^data_i[6:0], data_i[6:0], 1'b0} : {1'b1, data_i, 1'b0};
				mode_next  = sdi_mode_i;
				busy_next  = 1'b1;
				cnt_next   = '0;
				bit_next   = '0;
				line_next  = sdi_mode_i;
			end
		end else if (cnt_reg == W'(BIT_CYCLES - 1)) begin
			cnt_next = '0;
			if (bit_reg == 4'(sensor_resp_pkg::FRAME_BITS - 1)) begin
				busy_next = 1'b0;
				done_next = 1'b1;
				line_next = !mode_reg;
			end else begin
				bit_next   = bit_reg + 4'h1;
				shift_next = {1'b0, shift_reg[9:1]};
				line_next  = shift_reg[1] ^ mode_reg;
			end
		end else begin
			cnt_next = cnt_reg + W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_reg  <= 1'b0;
			mode_reg  <= 1'b0;
			cnt_reg   <= '0;
			bit_reg   <= '0;
			shift_reg <= '0;
			line_reg  <= 1'b1;
			done_reg  <= 1'b0;
		end else begin
			busy_reg  <= busy_next;
			mode_reg  <= mode_next;
			cnt_reg   <= cnt_next;
			bit_reg   <= bit_next;
			shift_reg <= shift_next;
			line_reg  <= line_next;
			done_reg  <= done_next;
		end
	end

	assign line_o = line_reg;
	assign done_o = done_reg;

	frame_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(busy_reg) |-> line_reg == mode_reg)
		else $error("start bit has wrong level");

endmodule // serial_char_tx

// file: sensor_serial_responder.sv
`timescale 1ns/1ps
// Functional notes
// - Data fetch replies address then signed values
// - First value is conductivity in uS/cm
// - Second value is temperature, one decimal
// - Change-address stores, echoes, then uses new
// - Wildcard accepted except for change-address
// - Factory address is zero
// - Only alphanumeric addresses accepted
// - Address query replies current address
// - At address zero, measure at power-up, then broadcast line
// - Broadcast uses 1200 baud 8N1 active-high
// - Line driven high within 100 ms
// - Line low for RAISE_CYCLES, then high until measured
// - After broadcast switch to bus mode
// - Nonzero address skips the broadcast
// - Broadcast field order tab..CR LF
// - Checksum is byte sum mod 64 plus 32
// - Bus uses 1200 baud inverted 7E1
// - Responses start with address, end CR LF
module sensor_serial_responder #(
	parameter int         BIT_CYCLES   = sensor_resp_pkg::BIT_CYCLES,
	parameter int         RAISE_CYCLES = sensor_resp_pkg::RAISE_CYCLES,
	parameter logic [7:0] TYPE_CHAR    = 8'h78 // Arbitrary sensor-type value
) (
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire logic        line_i,
	input  wire logic        meas_done_i,
	input  wire logic [23:0] cond_bcd_i,
	input  wire logic [11:0] temp_bcd_i,
	input  wire logic        temp_neg_i,
	input  wire logic [7:0]  addr_nv_i,
	output logic             line_o,
	output logic             line_oe_o,
	output logic             meas_start_o,
	output logic [7:0]       addr_o
);
	localparam int CW = sensor_resp_pkg::CNT_W;
	localparam int BW = sensor_resp_pkg::BIT_CNT_W;

	typedef enum logic [2:0] {
		ST_STRAP = 3'b000,
		ST_LOW   = 3'b001,
		ST_MEAS  = 3'b010,
		ST_BCAST = 3'b011,
		ST_IDLE  = 3'b100,
		ST_REPLY = 3'b101
	} state_e;

	logic rst_meta_reg, rst_n;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	state_e        state_reg, state_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic [7:0]    addr_reg, addr_next;
	logic          meas_start_reg, meas_start_next;
	logic          meas_got_reg, meas_got_next;
	logic [23:0]   cond_reg, cond_next;
	logic [11:0]   temp_reg, temp_next;
	logic          neg_reg, neg_next;
	logic [4:0]    step_reg, step_next;
	logic          wait_reg, wait_next;
	logic          short_reg, short_next;
	logic          nz_reg, nz_next;
	logic [5:0]    sum_reg, sum_next;
	logic          tx_go_reg, tx_go_next;
	logic [7:0]    tx_data_reg, tx_data_next;
	logic          line_reg, line_next;
	logic          oe_reg, oe_next;
	logic [7:0]    cmd_reg [sensor_resp_pkg::CMD_MAX];
	logic [7:0]    cmd_next [sensor_resp_pkg::CMD_MAX];
	logic [1:0]    cmd_len_reg, cmd_len_next;
	logic          over_reg, over_next;

	logic          sync1_reg, sync2_reg, sync3_reg, stable_reg, stable_next;
	logic          rx_busy_reg, rx_busy_next;
	logic [BW-1:0] rx_cnt_reg, rx_cnt_next;
	logic [3:0]    rx_bit_reg, rx_bit_next;
	logic [7:0]    rx_sh_reg, rx_sh_next;
	logic          rx_valid_reg, rx_valid_next;
	logic [7:0]    rx_char_reg, rx_char_next;

	logic          tx_line, tx_done, bcast, ch_skip, is_cdig, tx_sdi;
	logic [7:0]    ch;
	logic [3:0]    cdig;
	logic [2:0]    idx;

	serial_char_tx #(
		.BIT_CYCLES (BIT_CYCLES)
	) u_tx (
		.clk_i      (clk_sys_i),
		.rst_n_i    (rst_n),
		.start_i    (tx_go_reg),
		.data_i     (tx_data_reg),
		.sdi_mode_i (tx_sdi),
		.line_o     (tx_line),
		.done_o     (tx_done)
	);

	// Bus receiver: inverted levels, mid-bit sampling, even parity checked
	always_comb begin
		stable_next   = (sync2_reg == sync3_reg) ? sync3_reg : stable_reg;
		rx_busy_next  = rx_busy_reg;
		rx_cnt_next   = rx_cnt_reg;
		rx_bit_next   = rx_bit_reg;
		rx_sh_next    = rx_sh_reg;
		rx_valid_next = 1'b0;
		rx_char_next  = rx_char_reg;
		if (!rx_busy_reg) begin
			if (state_reg == ST_IDLE && stable_reg) begin
				rx_busy_next = 1'b1;
				rx_cnt_next  = BW'(BIT_CYCLES / 2);
				rx_bit_next  = '0;
			end
		end else if (rx_cnt_reg == BW'(BIT_CYCLES - 1)) begin
			rx_cnt_next = '0;
			rx_bit_next = rx_bit_reg + 4'h1;
			if (rx_bit_reg == 4'h0) begin
				rx_busy_next = stable_reg;
			end else if (rx_bit_reg < 4'(sensor_resp_pkg::FRAME_BITS - 1)) begin
				rx_sh_next = {!stable_reg, rx_sh_reg[7:1]};
			end else begin
				rx_busy_next = 1'b0;
				if (!stable_reg && !(^rx_sh_reg)) begin
					rx_valid_next = 1'b1;
					rx_char_next  = {1'b0, rx_sh_reg[6:0]};
				end
			end
		end else begin
			rx_cnt_next = rx_cnt_reg + BW'(1);
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg    <= 1'b0;
			sync2_reg    <= 1'b0;
			sync3_reg    <= 1'b0;
			stable_reg   <= 1'b0;
			rx_busy_reg  <= 1'b0;
			rx_cnt_reg   <= '0;
			rx_bit_reg   <= '0;
			rx_sh_reg    <= '0;
			rx_valid_reg <= 1'b0;
			rx_char_reg  <= '0;
		end else begin
			sync1_reg    <= line_i;
			sync2_reg    <= sync1_reg;
			sync3_reg    <= sync2_reg;
			stable_reg   <= stable_next;
			rx_busy_reg  <= rx_busy_next;
			rx_cnt_reg   <= rx_cnt_next;
			rx_bit_reg   <= rx_bit_next;
			rx_sh_reg    <= rx_sh_next;
			rx_valid_reg <= rx_valid_next;
			rx_char_reg  <= rx_char_next;
		end
	end

	// Character for the current response step; leading zeros are suppressed
	always_comb begin
		bcast   = (state_reg == ST_BCAST);
		// Transmitter idles high from the raise on, so no false edge precedes the first start bit
		tx_sdi  = !(state_reg inside {ST_LOW, ST_MEAS, ST_BCAST});
		idx     = 3'(sensor_resp_pkg::STEP_CDIG_LAST - step_reg);
		cdig    = 4'(cond_reg >> {idx, 2'b00});
		is_cdig = step_reg >= sensor_resp_pkg::STEP_CDIG0 && step_reg <= sensor_resp_pkg::STEP_CDIG_LAST;
		ch      = sensor_resp_pkg::CH_LF;
		ch_skip = 1'b0;
		if (is_cdig) begin
			ch      = sensor_resp_pkg::CH_ZERO | {4'h0, cdig};
			ch_skip = cdig == 4'h0 && !nz_reg && step_reg != sensor_resp_pkg::STEP_CDIG_LAST;
		end else begin
			case (step_reg)
				sensor_resp_pkg::STEP_PREFIX: ch = bcast ? sensor_resp_pkg::CH_TAB : addr_reg;
				sensor_resp_pkg::STEP_CSIGN: begin
					ch      = sensor_resp_pkg::CH_PLUS;
					ch_skip = bcast;
				end
				sensor_resp_pkg::STEP_SEP: begin
					ch = bcast ? sensor_resp_pkg::CH_SP
					   : (neg_reg ? sensor_resp_pkg::CH_MINUS : sensor_resp_pkg::CH_PLUS);
				end
				sensor_resp_pkg::STEP_TSIGN: begin
					ch      = sensor_resp_pkg::CH_MINUS;
					ch_skip = !bcast || !neg_reg;
				end
				sensor_resp_pkg::STEP_TTENS: begin
					ch      = sensor_resp_pkg::CH_ZERO | {4'h0, temp_reg[11:8]};
					ch_skip = temp_reg[11:8] == 4'h0;
				end
				sensor_resp_pkg::STEP_TUNITS: ch = sensor_resp_pkg::CH_ZERO | {4'h0, temp_reg[7:4]};
				sensor_resp_pkg::STEP_DOT:    ch = sensor_resp_pkg::CH_DOT;
				sensor_resp_pkg::STEP_TFRAC:  ch = sensor_resp_pkg::CH_ZERO | {4'h0, temp_reg[3:0]};
				sensor_resp_pkg::STEP_MCR: begin
					ch      = sensor_resp_pkg::CH_CR;
					ch_skip = !bcast;
				end
				sensor_resp_pkg::STEP_TYPE: begin
					ch      = TYPE_CHAR;
					ch_skip = !bcast;
				end
				sensor_resp_pkg::STEP_CSUM: begin
					ch      = sensor_resp_pkg::CSUM_OFFSET + {2'b00, sum_reg};
					ch_skip = !bcast;
				end
				sensor_resp_pkg::STEP_CR: ch = sensor_resp_pkg::CH_CR;
				default: ch = sensor_resp_pkg::CH_LF;
			endcase
		end
	end

	always_comb begin
		state_next      = state_reg;
		cnt_next        = cnt_reg;
		addr_next       = addr_reg;
		meas_start_next = 1'b0;
		meas_got_next   = meas_got_reg | meas_done_i;
		cond_next       = cond_reg;
		temp_next       = temp_reg;
		neg_next        = neg_reg;
		step_next       = step_reg;
		wait_next       = wait_reg;
		short_next      = short_reg;
		nz_next         = nz_reg;
		sum_next        = sum_reg;
		tx_go_next      = 1'b0;
		tx_data_next    = tx_data_reg;
		line_next       = line_reg;
		oe_next         = oe_reg;
		cmd_next        = cmd_reg;
		cmd_len_next    = cmd_len_reg;
		over_next       = over_reg;
		case (state_reg)
			ST_STRAP: begin
				addr_next = sensor_resp_pkg::is_alnum(addr_nv_i) ? addr_nv_i : sensor_resp_pkg::ADDR_RESET;
				if (addr_next != sensor_resp_pkg::ADDR_RESET) begin
					state_next = ST_IDLE;
				end else begin
					state_next      = ST_LOW;
					meas_start_next = 1'b1;
					meas_got_next   = 1'b0;
					cnt_next        = '0;
					oe_next         = 1'b1;
					line_next       = 1'b0;
				end
			end
			ST_LOW: begin
				if (cnt_reg == CW'(RAISE_CYCLES - 1)) begin
					state_next = ST_MEAS;
					line_next  = 1'b1;
				end else begin
					cnt_next = cnt_reg + CW'(1);
				end
			end
			ST_MEAS: begin
				if (meas_got_reg) begin
					state_next = ST_BCAST;
					short_next = 1'b0;
					step_next  = sensor_resp_pkg::STEP_PREFIX;
					wait_next  = 1'b0;
					nz_next    = 1'b0;
					sum_next   = '0;
					cond_next  = cond_bcd_i;
					temp_next  = temp_bcd_i;
					neg_next   = temp_neg_i;
				end
			end
			ST_BCAST, ST_REPLY: begin
				line_next = tx_line;
				if (!wait_reg) begin
					if (ch_skip) begin
						step_next = step_reg + 5'h01;
					end else begin
						tx_go_next   = 1'b1;
						tx_data_next = ch;
						wait_next    = 1'b1;
						nz_next      = nz_reg | (is_cdig && ch != sensor_resp_pkg::CH_ZERO);
						if (step_reg < sensor_resp_pkg::STEP_CSUM) begin
							sum_next = sum_reg + ch[5:0];
						end
					end
				end else if (tx_done) begin
					wait_next = 1'b0;
					if (step_reg == sensor_resp_pkg::STEP_LF) begin
						state_next = ST_IDLE;
						oe_next    = 1'b0;
					end else if (short_reg && step_reg == sensor_resp_pkg::STEP_PREFIX) begin
						step_next = sensor_resp_pkg::STEP_CR;
					end else begin
						step_next = step_reg + 5'h01;
					end
				end
			end
			default: begin
				oe_next = 1'b0;
				line_next = 1'b0; // Mark level, so a reply opens without a spurious start bit
				if (rx_valid_reg) begin
					if (rx_char_reg == sensor_resp_pkg::CH_BANG) begin
						cmd_len_next = '0;
						over_next    = 1'b0;
						short_next   = 1'b1;
						step_next    = sensor_resp_pkg::STEP_PREFIX;
						wait_next    = 1'b0;
						nz_next      = 1'b0;
						cond_next    = cond_bcd_i;
						temp_next    = temp_bcd_i;
						neg_next     = temp_neg_i;
						if (over_reg) begin
							state_next = ST_IDLE;
						end else if (cmd_len_reg == 2'd1 && (cmd_reg[0] == addr_reg ||
								cmd_reg[0] == sensor_resp_pkg::CH_WILD)) begin
							state_next = ST_REPLY;
						end else if (cmd_len_reg == 2'd3 && cmd_reg[1] == sensor_resp_pkg::CH_D &&
								cmd_reg[2] == sensor_resp_pkg::CH_ZERO && (cmd_reg[0] == addr_reg ||
								cmd_reg[0] == sensor_resp_pkg::CH_WILD)) begin
							state_next = ST_REPLY;
							short_next = 1'b0;
						end else if (cmd_len_reg == 2'd3 && cmd_reg[1] == sensor_resp_pkg::CH_A &&
								cmd_reg[0] == addr_reg && sensor_resp_pkg::is_alnum(cmd_reg[2])) begin
							state_next = ST_REPLY;
							addr_next  = cmd_reg[2];
						end
					end else if (cmd_len_reg == 2'(sensor_resp_pkg::CMD_MAX)) begin
						over_next = 1'b1;
					end else begin
						cmd_next[cmd_len_reg] = rx_char_reg;
						cmd_len_next          = cmd_len_reg + 2'd1;
					end
				end
				if (state_next == ST_REPLY) begin
					oe_next = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg      <= ST_STRAP;
			cnt_reg        <= '0;
			addr_reg       <= sensor_resp_pkg::ADDR_RESET;
			meas_start_reg <= 1'b0;
			meas_got_reg   <= 1'b0;
			cond_reg       <= '0;
			temp_reg       <= '0;
			neg_reg        <= 1'b0;
			step_reg       <= '0;
			wait_reg       <= 1'b0;
			short_reg      <= 1'b0;
			nz_reg         <= 1'b0;
			sum_reg        <= '0;
			tx_go_reg      <= 1'b0;
			tx_data_reg    <= '0;
			line_reg       <= 1'b0;
			oe_reg         <= 1'b0;
			cmd_reg        <= '{default: '0};
			cmd_len_reg    <= '0;
			over_reg       <= 1'b0;
		end else begin
			state_reg      <= state_next;
			cnt_reg        <= cnt_next;
			addr_reg       <= addr_next;
			meas_start_reg <= meas_start_next;
			meas_got_reg   <= meas_got_next;
			cond_reg       <= cond_next;
			temp_reg       <= temp_next;
			neg_reg        <= neg_next;
			step_reg       <= step_next;
			wait_reg       <= wait_next;
			short_reg      <= short_next;
			nz_reg         <= nz_next;
			sum_reg        <= sum_next;
			tx_go_reg      <= tx_go_next;
			tx_data_reg    <= tx_data_next;
			line_reg       <= line_next;
			oe_reg         <= oe_next;
			cmd_reg        <= cmd_next;
			cmd_len_reg    <= cmd_len_next;
			over_reg       <= over_next;
		end
	end

	assign line_o       = line_reg;
	assign line_oe_o    = oe_reg;
	assign meas_start_o = meas_start_reg;
	assign addr_o       = addr_reg;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n);

	logic seq_pick, bang_ok;
	assign seq_pick = !wait_reg && !ch_skip && (state_reg == ST_BCAST || state_reg == ST_REPLY);
	assign bang_ok  = state_reg == ST_IDLE && rx_valid_reg && rx_char_reg == sensor_resp_pkg::CH_BANG && !over_reg;

	data_prefix_a: assert property (seq_pick && state_reg == ST_REPLY && step_reg == sensor_resp_pkg::STEP_PREFIX
		|=> tx_go_reg && tx_data_reg == addr_reg) else $error("reply does not start with address");
	value_sign_a: assert property (seq_pick && state_reg == ST_REPLY && step_reg == sensor_resp_pkg::STEP_CSIGN
		|=> tx_data_reg == sensor_resp_pkg::CH_PLUS) else $error("conductivity sign missing");
	temp_sign_a: assert property (seq_pick && state_reg == ST_REPLY && step_reg == sensor_resp_pkg::STEP_SEP
		|=> tx_data_reg == (neg_reg ? sensor_resp_pkg::CH_MINUS : sensor_resp_pkg::CH_PLUS))
		else $error("temperature sign wrong");
	cond_digit_a: assert property (seq_pick && step_reg == sensor_resp_pkg::STEP_CDIG_LAST
		|=> tx_data_reg == (sensor_resp_pkg::CH_ZERO | {4'h0, cond_reg[3:0]})) else $error("last conductivity digit wrong");
	temp_frac_a: assert property (seq_pick && step_reg == sensor_resp_pkg::STEP_TFRAC
		|=> tx_data_reg == (sensor_resp_pkg::CH_ZERO | {4'h0, temp_reg[3:0]})) else $error("tenths digit wrong");
	addr_change_a: assert property (bang_ok && cmd_len_reg == 2'd3 && cmd_reg[1] == sensor_resp_pkg::CH_A &&
		cmd_reg[0] == addr_reg && sensor_resp_pkg::is_alnum(cmd_reg[2])
		|=> addr_reg == $past(cmd_reg[2]) && state_reg == ST_REPLY && short_reg) else $error("address not changed");
	change_exact_a: assert property (bang_ok && cmd_reg[0] == sensor_resp_pkg::CH_WILD &&
		cmd_reg[1] == sensor_resp_pkg::CH_A |=> $stable(addr_reg)) else $error("wildcard changed address");
	addr_alnum_a: assert property (sensor_resp_pkg::is_alnum(addr_reg))
		else $error("address not alphanumeric");
	factory_addr_a: assert property (state_reg == ST_STRAP |-> addr_reg == sensor_resp_pkg::ADDR_RESET)
		else $error("reset address not zero");
	query_a: assert property (bang_ok && cmd_len_reg == 2'd1 && cmd_reg[0] == sensor_resp_pkg::CH_WILD
		|=> state_reg == ST_REPLY && short_reg) else $error("query not answered");
	skip_bcast_a: assert property (state_reg == ST_STRAP && sensor_resp_pkg::is_alnum(addr_nv_i) &&
		addr_nv_i != sensor_resp_pkg::ADDR_RESET |=> state_reg == ST_IDLE) else $error("broadcast not skipped");
	no_rebcast_a: assert property (state_reg inside {ST_IDLE, ST_REPLY}
		|=> state_reg inside {ST_IDLE, ST_REPLY}) else $error("broadcast repeated");
	line_low_a: assert property (state_reg == ST_LOW |-> line_oe_o && !line_o
		&& cnt_reg < CW'(sensor_resp_pkg::RAISE_MAX_CYCLES)) else $error("line not low while measuring");
	line_high_a: assert property (state_reg == ST_MEAS |-> line_oe_o && line_o)
		else $error("line not raised");
	bcast_tab_a: assert property (seq_pick && bcast && step_reg == sensor_resp_pkg::STEP_PREFIX
		|=> tx_data_reg == sensor_resp_pkg::CH_TAB) else $error("broadcast does not open with tab");
	csum_a: assert property (seq_pick && bcast && step_reg == sensor_resp_pkg::STEP_CSUM
		|=> tx_data_reg == sensor_resp_pkg::CSUM_OFFSET + {2'b00, $past(sum_reg)}) else $error("checksum wrong");

	bcast_done_c: cover property (state_reg == ST_BCAST ##1 state_reg == ST_IDLE);
	data_reply_c: cover property (state_reg == ST_REPLY && !short_reg && step_reg == sensor_resp_pkg::STEP_LF);
	addr_chg_c:   cover property (state_reg == ST_IDLE ##1 $changed(addr_reg));
	query_c:      cover property (bang_ok && cmd_reg[0] == sensor_resp_pkg::CH_WILD && cmd_len_reg == 2'd1);

endmodule // sensor_serial_responder

// file: logger_model.sv
`timescale 1ns/1ps
module logger_model #(
	parameter int BIT_CYCLES = 16
) (
	input  wire logic clk_i,
	input  wire logic wire_i,
	output logic      drive_o,
	output logic      oe_o
);
	initial begin
		drive_o = 1'b0;
		oe_o    = 1'b0;
	end
	// Inverted 7E1 command character, then the wire is let go
	task automatic send(input logic [7:0] c);
		logic [9:0] f;
		f = {1'b1, ^c[6:0], c[6:0], 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_i);
			oe_o    <= 1'b1;
			drive_o <= ~f[i];
			repeat (BIT_CYCLES - 1) @(negedge clk_i);
		end
		@(negedge clk_i);
		oe_o <= 1'b0;
	endtask
	// Framing begins only at a start bit; in bus mode bit 7 flags bad parity or stop
	task automatic recv(input logic sdi, output logic [7:0] c);
		logic [8:0] b;
		wait (wire_i == sdi);
		repeat (BIT_CYCLES / 2) @(negedge clk_i);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CYCLES) @(negedge clk_i);
			b[i] = wire_i;
		end
		c = sdi ? {(^b[7:0]) | b[8], ~b[6:0]} : b[7:0];
	endtask
endmodule // logger_model

// file: sensor_serial_responder_tb.sv
`timescale 1ns/1ps
module sensor_serial_responder_tb;
	localparam int         BITC    = 16;
	localparam logic [7:0] TYPE_CH = 8'h6B; // Arbitrary sensor-type value
	logic        clk_sys_i, nrst_i, meas_done_i, temp_neg_i, line_o, line_oe_o, meas_start_o, lg_drv, lg_oe;
	logic [23:0] cond_bcd_i;
	logic [11:0] temp_bcd_i;
	logic [7:0]  addr_nv_i, addr_o, rx;
	int          err_count = 0, num_checks = 0, sum;
	wire         line_w = line_oe_o ? line_o : (lg_oe ? lg_drv : 1'b0);

	sensor_serial_responder #(.BIT_CYCLES(BITC), .RAISE_CYCLES(20), .TYPE_CHAR(TYPE_CH)) sensor_serial_responder_i (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .line_i(line_w), .meas_done_i(meas_done_i),
		.cond_bcd_i(cond_bcd_i), .temp_bcd_i(temp_bcd_i), .temp_neg_i(temp_neg_i), .addr_nv_i(addr_nv_i),
		.line_o(line_o), .line_oe_o(line_oe_o), .meas_start_o(meas_start_o), .addr_o(addr_o));
	logger_model #(.BIT_CYCLES(BITC)) logger_model_i (.clk_i(clk_sys_i), .wire_i(line_w), .drive_o(lg_drv),
		.oe_o(lg_oe));

	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic send_str(input string s);
		repeat (2 * BITC) @(negedge clk_sys_i);
		for (int i = 0; i < s.len(); i++)
			logger_model_i.send(s[i]);
	endtask
	task automatic rx_str(input logic sdi, input string s);
		for (int i = 0; i < s.len(); i++) begin
			logger_model_i.recv(sdi, rx);
			sum += s[i];
			chk("char", s[i], rx);
		end
	endtask
	task automatic power_up(input logic [7:0] nv);
		@(negedge clk_sys_i);
		nrst_i    = 1'b0;
		addr_nv_i = nv;
		repeat (12) @(negedge clk_sys_i);
		nrst_i = 1'b1;
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic t_broadcast();
		for (int n = 0; n < 20 && meas_start_o !== 1'b1; n++)
			@(negedge clk_sys_i);
		chk("start", 8'h01, {7'h0, meas_start_o});
		chk("low", 8'h02, {6'h0, line_oe_o, line_o});
		repeat (25) @(negedge clk_sys_i);
		chk("raised", 8'h03, {6'h0, line_oe_o, line_o});
		meas_done_i = 1'b1;
		@(negedge clk_sys_i);
		meas_done_i = 1'b0;
		sum = 0;
		rx_str(1'b0, "\t5423 -2.3\015");
		logger_model_i.recv(1'b0, rx);
		chk("type", TYPE_CH, rx);
		sum += TYPE_CH;
		logger_model_i.recv(1'b0, rx);
		chk("checksum", 8'(sum % 64 + 32), rx);
		rx_str(1'b0, "\015\012");
		repeat (2 * BITC) @(negedge clk_sys_i);
		chk("released", 8'h00, {7'h0, line_oe_o});
	endtask
	task automatic t_addr();
		send_str("?!");
		rx_str(1'b1, "0\015\012");
		send_str("?A5!");
		repeat (3 * BITC) @(negedge clk_sys_i);
		chk("wild rename", 8'h30, addr_o);
		send_str("0A5!");
		rx_str(1'b1, "5\015\012");
		chk("address", 8'h35, addr_o);
		send_str("5A*!");
		repeat (3 * BITC) @(negedge clk_sys_i);
		chk("bad address", 8'h35, addr_o);
		send_str("5!");
		rx_str(1'b1, "5\015\012");
	endtask
	initial begin
		nrst_i      = 1'b0;
		meas_done_i = 1'b0;
		temp_neg_i  = 1'b1;
		cond_bcd_i  = 24'h005423;
		temp_bcd_i  = 12'h023;
		power_up(8'h30);
		chk("factory", 8'h30, addr_o);
		t_broadcast();
		send_str("0M!");
		repeat (3 * BITC) @(negedge clk_sys_i);
		chk("measure ignored", 8'h00, {7'h0, line_oe_o});
		send_str("0D0!");
		rx_str(1'b1, "0+5423-2.3\015\012");
		t_addr();
		power_up(8'h35);
		temp_neg_i = 1'b0;
		repeat (40) @(negedge clk_sys_i);
		chk("no broadcast", 8'h00, {7'h0, line_oe_o});
		send_str("?D0!");
		rx_str(1'b1, "5+5423+2.3\015\012");
		finish_test();
	end
	initial begin
		#2_000_000;
		err_count++;
		finish_test();
	end
endmodule // sensor_serial_responder_tb
